// >>> include/pwr_mode_map.svh
// Constants for the power-mode controller and its host end
`ifndef PWR_MODE_MAP_SVH
`define PWR_MODE_MAP_SVH
`define BOOT_TIME_NS 1000
`define BOOT_CYCLES ((`BOOT_TIME_NS + 49) / 50)
`define DEEP_ACTIVE_LEVEL 1'b0
`define DEEP_RELEASE_LEVEL 1'b1
`define REQ_WIDTH_CYCLES 2
`define IO_WIDTH 8
`endif

// >>> include/pwr_mode_pkg.sv
// Types shared by the power-mode controller and its host end
package pwr_mode_pkg;
    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_BOOT = 5'h02,
        ST_RUN = 5'h04,
        ST_PDOWN = 5'h08,
        ST_DEEP = 5'h10
    } pmode_e;
endpackage

// >>> include/pwr_link_if.sv
// Pins between the power-mode device end and its host end
`timescale 1ns/1ns
interface pwr_link_if;
    logic sda_host_oe;
    logic sda_dev_oe;
    logic sda;
    logic session_end;
    logic deep_sleep_enable_pin;
    logic card_rst_n;
    logic card_if_enabled;
    assign sda = ~(sda_host_oe | sda_dev_oe);
    modport dev (input sda, input session_end, input deep_sleep_enable_pin, input card_rst_n,
        input card_if_enabled, output sda_dev_oe);
    modport host (input sda, output sda_host_oe, output session_end, output deep_sleep_enable_pin,
        output card_rst_n, output card_if_enabled);
endinterface

// >>> design/pwr_mode_dev.sv
// Device end: retentive power-down and deep power-down control
//
// Overview of operation
// - Two low-power states, retentive and deep
// - Session-end request enters retentive power-down
// - Power-down freezes clocks, halts core, keeps data
// - Pad outputs and SDA drive hold levels from power-down entry
// - SDA falling edge wakes from power-down
// - Card reset pulse wakes to idle, if enabled
// - Deep-sleep pin low switches power domain off
// - Deep-sleep pin high leaves deep power-down
// - Deep power-down discards all internal state
`timescale 1ns/1ns
`include "pwr_mode_map.svh"
module pwr_mode_dev #(
    parameter int BOOT_CYC = `BOOT_CYCLES,
    parameter int IO_W = `IO_WIDTH
) (
    input wire logic clk,
    input wire logic srst,
    pwr_link_if.dev link,
    input wire logic [IO_W-1:0] core_io,
    input wire logic sda_drive_low,
    output pwr_mode_pkg::pmode_e mode,
    output logic core_clk_en,
    output logic domain_power_on,
    output logic retain_en,
    output logic idle_wake,
    output logic [IO_W-1:0] io_out,
    output logic sda_oe
);
    import pwr_mode_pkg::*;

    // Boot timer end point, cut to the counter width on purpose
    localparam logic [15:0] BOOT_LAST = 16'(BOOT_CYC - 1);

    // Power sequencing state, wake decode and boot timer
    pmode_e state_q;
    logic sda_prev_q;
    logic [15:0] boot_cnt_q;
    logic sda_fall;
    logic deep_req;
    logic card_wake;
    logic boot_done;

    // Switched domain has no supply in these states
    function automatic logic unpowered(
        input pmode_e s
    );
        return s == ST_DEEP || s == ST_OFF;
    endfunction

    // Core clock runs and pads follow the core only here
    function automatic logic core_active(
        input pmode_e s
    );
        return s == ST_RUN;
    endfunction

    // Retentive power-down: clocks frozen, contents kept
    function automatic logic retained(
        input pmode_e s
    );
        return s == ST_PDOWN;
    endfunction

    // Wake edge taken from registered SDA history against the live SDA pin
    assign sda_fall = sda_prev_q & ~link.sda;
    assign deep_req = link.deep_sleep_enable_pin == `DEEP_ACTIVE_LEVEL;
    // Card reset counts only with the contact interface on; an SDA edge wins a tie
    assign card_wake = link.card_if_enabled & ~link.card_rst_n & ~sda_fall;
    // Boot ends on the last count, not one past it
    assign boot_done = boot_cnt_q >= BOOT_LAST;

    // History resets to the idle high level, so reset gives no false wake
    always_ff @(posedge clk) begin
        if (srst) begin
            sda_prev_q <= 1'b1;
        end else begin
            sda_prev_q <= link.sda;
        end
    end

    // Deep request overrides every state, boot included
    // Both OFF and DEEP boot again before RUN, as after power-on
    // Session end is ignored outside RUN, wake sources outside power-down
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_OFF;
        end else if (deep_req) begin
            state_q <= ST_DEEP;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    state_q <= ST_BOOT;
                end
                ST_DEEP: begin
                    state_q <= ST_BOOT;
                end
                ST_BOOT: begin
                    if (boot_done) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (link.session_end) begin
                        state_q <= ST_PDOWN;
                    end
                end
                ST_PDOWN: begin
                    if (sda_fall) begin
                        state_q <= ST_RUN;
                    end else if (card_wake) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Timer idles at zero outside BOOT, so each boot starts a full count
    always_ff @(posedge clk) begin
        if (srst) begin
            boot_cnt_q <= 16'h0000;
        end else if (deep_req || state_q != ST_BOOT) begin
            boot_cnt_q <= 16'h0000;
        end else if (!boot_done) begin
            boot_cnt_q <= boot_cnt_q + 16'h0001;
        end
    end

    // Mode shows the state one cycle late, like the other flags
    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= ST_OFF;
        end else begin
            mode <= state_q;
        end
    end

    // Core halted whenever it is not running
    always_ff @(posedge clk) begin
        if (srst) begin
            core_clk_en <= 1'b0;
        end else begin
            core_clk_en <= core_active(state_q);
        end
    end

    // Domain supply off in OFF and DEEP
    always_ff @(posedge clk) begin
        if (srst) begin
            domain_power_on <= 1'b0;
        end else begin
            domain_power_on <= !unpowered(state_q);
        end
    end

    // Tells the core to keep registers and memory
    always_ff @(posedge clk) begin
        if (srst) begin
            retain_en <= 1'b0;
        end else begin
            retain_en <= retained(state_q);
        end
    end

    // Idle flag marks a card-reset wake; cleared once the state leaves RUN
    // Set wins over clear, as both can fall in the wake cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            idle_wake <= 1'b0;
        end else if (retained(state_q) && card_wake) begin
            idle_wake <= 1'b1;
        end else if (!core_active(state_q)) begin
            idle_wake <= 1'b0;
        end
    end

    // Pads keep the level driven at power-down entry; a frozen core cannot refresh them
    // Zeroed when unpowered, since nothing survives deep power-down
    always_ff @(posedge clk) begin
        if (srst) begin
            io_out <= '0;
        end else if (core_active(state_q)) begin
            io_out <= core_io;
        end else if (unpowered(state_q)) begin
            io_out <= '0;
        end
    end

    // A held-low SDA blocks the SDA wake; only a card reset or a deep request can then end power-down
    // Released when unpowered, so the host keeps the bus
    always_ff @(posedge clk) begin
        if (srst) begin
            sda_oe <= 1'b0;
        end else if (core_active(state_q)) begin
            sda_oe <= sda_drive_low;
        end else if (unpowered(state_q)) begin
            sda_oe <= 1'b0;
        end
    end

    assign link.sda_dev_oe = sda_oe;
endmodule // pwr_mode_dev

// >>> design/pwr_mode_host.sv
// Host end: session end, SDA wake, card reset and deep-sleep pin
`timescale 1ns/1ns
`include "pwr_mode_map.svh"
module pwr_mode_host (
    input wire logic clk,
    input wire logic srst,
    pwr_link_if.host link,
    input wire logic end_session,
    input wire logic wake,
    input wire logic card_reset,
    input wire logic deep_enter,
    input wire logic deep_leave,
    input wire logic card_enable,
    output logic busy
);
    import pwr_mode_pkg::*;

    logic sess_q;
    logic sda_low_q;
    logic card_rst_n_q;
    logic [1:0] cnt_q;
    logic deep_pin_q;
    logic card_en_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            sess_q <= 1'b0;
            sda_low_q <= 1'b0;
            card_rst_n_q <= 1'b1;
            cnt_q <= 2'h0;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                sess_q <= 1'b0;
                sda_low_q <= 1'b0;
                card_rst_n_q <= 1'b1;
            end
        end else if (end_session) begin
            sess_q <= 1'b1;
            cnt_q <= 2'(`REQ_WIDTH_CYCLES);
        end else if (wake) begin
            sda_low_q <= 1'b1;
            cnt_q <= 2'(`REQ_WIDTH_CYCLES);
        end else if (card_reset) begin
            card_rst_n_q <= 1'b0;
            cnt_q <= 2'(`REQ_WIDTH_CYCLES);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            deep_pin_q <= `DEEP_RELEASE_LEVEL;
            card_en_q <= 1'b0;
            busy <= 1'b0;
        end else begin
            if (deep_enter) begin
                deep_pin_q <= `DEEP_ACTIVE_LEVEL;
            end else if (deep_leave) begin
                deep_pin_q <= `DEEP_RELEASE_LEVEL;
            end
            card_en_q <= card_enable;
            busy <= cnt_q != 2'h0 || end_session || wake || card_reset;
        end
    end

    assign link.session_end = sess_q;
    assign link.sda_host_oe = sda_low_q;
    assign link.card_rst_n = card_rst_n_q;
    assign link.deep_sleep_enable_pin = deep_pin_q;
    assign link.card_if_enabled = card_en_q;
endmodule // pwr_mode_host

// >>> tb/pwr_mode_control_props.sv
// Checker on the pins between the device end and the host end
`timescale 1ns/1ns
module power_saving_mode_control_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic sda_host_oe,
    input wire logic sda_dev_oe,
    input wire logic sda,
    input wire logic session_end,
    input wire logic deep_sleep_enable_pin,
    input wire logic card_rst_n,
    input wire logic card_if_enabled
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sess_pulse_a: assert property ($rose(session_end) |=> session_end ##1 !session_end)
        else $error("session pulse width");
    wake_pulse_a: assert property ($rose(sda_host_oe) |=> sda_host_oe ##1 !sda_host_oe)
        else $error("wake pulse width");
    wake_level_a: assert property (sda_host_oe |-> !sda)
        else $error("sda not low on wake");
    card_pulse_a: assert property ($fell(card_rst_n) |=> !card_rst_n ##1 card_rst_n)
        else $error("card reset width");
    reset_idle_a: assert property ($fell(srst) |-> deep_sleep_enable_pin && card_rst_n && !session_end)
        else $error("host pins not idle");
    one_request_a: assert property (session_end |-> !sda_host_oe && card_rst_n)
        else $error("overlapping requests");
    deep_hold_a: assert property ($fell(deep_sleep_enable_pin) |=> !deep_sleep_enable_pin)
        else $error("deep pin not held");
    dev_release_a: assert property (!deep_sleep_enable_pin [*3] |-> !sda_dev_oe)
        else $error("sda driven in deep");
    cover property ($rose(session_end));
    cover property ($fell(card_rst_n) && card_if_enabled);
    cover property ($fell(deep_sleep_enable_pin));
endmodule // power_saving_mode_control_props

// >>> tb/power_saving_mode_control_tb.sv
// Testbench joining the device and host ends with a mode model
`timescale 1ns/1ns
module power_saving_mode_control_tb;
    import pwr_mode_pkg::*;
    logic clk, srst, card_en, core_clk_en, domain_power_on, retain_en, idle_wake, sda_oe, busy, sda_low;
    logic [4:0] req;
    logic [7:0] core_io, io_out, held, io_seen;
    pmode_e mode, exp;
    int n_errors = 0, tests_run = 0, seed = 69532;
    pwr_link_if link ();
    pwr_mode_dev #(.BOOT_CYC(2), .IO_W(8)) i_pwr_mode_dev (.clk(clk), .srst(srst), .link(link),
        .core_io(core_io), .sda_drive_low(sda_low), .mode(mode), .core_clk_en(core_clk_en),
        .domain_power_on(domain_power_on), .retain_en(retain_en), .idle_wake(idle_wake),
        .io_out(io_out), .sda_oe(sda_oe));
    pwr_mode_host i_pwr_mode_host (.clk(clk), .srst(srst), .link(link), .end_session(req[0]),
        .wake(req[1]), .card_reset(req[2]), .deep_enter(req[3]), .deep_leave(req[4]),
        .card_enable(card_en), .busy(busy));
    power_saving_mode_control_props i_props (.clk(clk), .srst(srst), .sda_host_oe(link.sda_host_oe),
        .sda_dev_oe(link.sda_dev_oe), .sda(link.sda), .session_end(link.session_end),
        .deep_sleep_enable_pin(link.deep_sleep_enable_pin), .card_rst_n(link.card_rst_n),
        .card_if_enabled(link.card_if_enabled));
    task chk(input string what, input logic [7:0] seen, input logic [7:0] expv);
        tests_run++;
        if (seen !== expv) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task end_of_test;
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Model steps the expected mode, then the design gets 8 cycles to settle
    task op(input int k);
        @(posedge clk);
        req <= 5'h01 << k;
        @(posedge clk);
        req <= 5'h00;
        #1 chk("busy", 8'(busy), (k < 3) ? 8'h01 : 8'h00);
        case (k)
            0: if (exp == ST_RUN) exp = ST_PDOWN;
            1: if (exp == ST_PDOWN) exp = ST_RUN;
            2: if (exp == ST_PDOWN && card_en) exp = ST_RUN;
            3: exp = ST_DEEP;
            default: exp = ST_RUN;
        endcase
        repeat (8) @(posedge clk);
        #1 chk("mode", 8'(mode), 8'(exp));
    endtask
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // Random pad data keeps the hold check meaningful
    always @(posedge clk) begin
        core_io <= 8'($random(seed));
        io_seen <= core_io;
    end
    initial begin
        #100000 n_errors++;
        end_of_test;
    end
    initial begin
        srst = 1;
        req = 5'h00;
        card_en = 0;
        sda_low = 0;
        exp = ST_RUN;
        repeat (4) @(posedge clk);
        #1 chk("rst_mode", 8'(mode), 8'(ST_OFF));
        chk("rst_power", 8'(domain_power_on), 8'h00);
        chk("rst_busy", 8'(busy), 8'h00);
        @(posedge clk);
        srst <= 0;
        repeat (10) @(posedge clk);
        #1 chk("boot", 8'(mode), 8'(ST_RUN));
        chk("io_run", io_out, io_seen);
        op(0);
        chk("clk_en", 8'(core_clk_en), 8'h00);
        chk("retain", 8'(retain_en), 8'h01);
        held = io_out;
        repeat (4) @(posedge clk);
        #1 chk("io_hold", io_out, held);
        op(2);
        op(1);
        @(posedge clk) card_en <= 1;
        op(0);
        op(2);
        chk("idle", 8'(idle_wake), 8'h01);
        @(posedge clk) sda_low <= 1;
        op(0);
        chk("sda_hold", 8'(sda_oe), 8'h01);
        chk("idle_clr", 8'(idle_wake), 8'h00);
        op(3);
        chk("power", 8'(domain_power_on), 8'h00);
        chk("io_deep", io_out, 8'h00);
        chk("sda_deep", 8'(sda_oe), 8'h00);
        op(4);
        chk("power_up", 8'(domain_power_on), 8'h01);
        chk("sda_run", 8'(sda_oe), 8'h01);
        end_of_test;
    end
endmodule // power_saving_mode_control_tb
